// File: bench/spc_checker_top_tb.sv
module spc_checker_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic core_clk, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_ip = 32'h0;
    logic wb_ack_o, req_valid, req_ready, grant, general_protection_fault;
    logic [2:0] fault_cause;
    spc_pkg::spc_kind_t req_kind;
    logic [15:0] req_selector, exp_sel [6] = '{default: 16'h0};
    logic [63:0] req_descriptor, req_offset;
    logic [31:0] exp_dlo [6] = '{default: 32'h0};
    logic [7:0] n = 8'h0;
    int n_errors = 0, total_checks = 0, cycles = 0;
    spc_checker_top dut (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_ack_o, .wb_dat_o, .req_valid, .req_kind, .req_selector, .req_descriptor,
        .req_offset, .req_ready, .grant, .general_protection_fault, .fault_cause);
    spc_exec_model u_exec (.core_clk, .req_ready, .grant, .general_protection_fault, .fault_cause,
        .req_valid, .req_kind, .req_selector, .req_descriptor, .req_offset);
    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // One request, then selectors, IP low word, one hidden descriptor word, ctrl and status compared
    task automatic go(input int k, input logic [1:0] current_priv_level, requestor_priv_level, descriptor_priv_level, input logic cf, lm);
        logic g, f, ok;
        logic [2:0] c, cs;
        logic [31:0] q;
        logic [63:0] dsc;
        logic [15:0] s;
        int seg;
        n = n + 8'h01;
        s = {6'h00, n, requestor_priv_level};
        dsc = {17'h0, descriptor_priv_level, 2'h0, cf, 10'h0, 24'ha5a5a5, n};
        seg = (k < 4) ? k : ((k == 4) ? 4 : 5);
        wb(1'b1, spc_pkg::ADDR_CTRL, {29'h0, lm, current_priv_level}, q);
        u_exec.issue(spc_pkg::spc_kind_t'(k[3:0]), s, dsc, {56'h0, n}, g, f, c);
        case (k)
            0, 1, 2, 3: cs = (((current_priv_level > requestor_priv_level) ? current_priv_level : requestor_priv_level) <= descriptor_priv_level) ? 3'h0 : 3'h1;
            4: cs = (requestor_priv_level != current_priv_level) ? 3'h2 : ((descriptor_priv_level != current_priv_level) ? 3'h3 : 3'h0);
            5: if (cf) cs = (descriptor_priv_level > current_priv_level) ? 3'h6 : 3'h0;
               else cs = (descriptor_priv_level != current_priv_level) ? 3'h4 : ((requestor_priv_level > current_priv_level) ? 3'h5 : 3'h0);
            6: cs = 3'h0;
            default: cs = lm ? 3'h7 : 3'h0;
        endcase
        ok = (cs == 3'h0);
        check("grant", {31'h0, g}, {31'h0, ok});
        check("fault", {31'h0, f}, {31'h0, ~ok});
        check("cause", {29'h0, c}, {29'h0, cs});
        if (ok && k < 6)
            exp_sel[seg] = (k == 5) ? {s[15:2], current_priv_level} : s;
        if (ok && k < 6)
            exp_dlo[seg] = dsc[31:0];
        if (ok && (k == 5 || k == 6))
            exp_ip = {24'h0, n};
        for (int p = 0; p < 3; p++)
        begin
            wb(1'b0, 8'h08 + 8'(4 * p), 32'h0, q);
            check("selectors", q, {exp_sel[2 * p + 1], exp_sel[2 * p]});
        end
        wb(1'b0, spc_pkg::ADDR_IP_LO, 32'h0, q);
        check("ip", q, exp_ip);
        wb(1'b0, 8'h40 + 8'(8 * seg), 32'h0, q);
        check("hidden", q, exp_dlo[seg]);
        wb(1'b0, spc_pkg::ADDR_CTRL, 32'h0, q);
        check("ctrl", q, {29'h0, lm, current_priv_level});
        wb(1'b0, spc_pkg::ADDR_STATUS, 32'h0, q);
        check("status", q, {24'h0, 1'b0, k[3:0], cs});
        check("ready", {31'h0, req_ready}, 32'h1);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        wb(1'b0, spc_pkg::ADDR_CTRL, 32'h0, q);
        check("ctrl reset", q, 32'h0);
        for (int i = 0; i < 64; i++)
            go((i >> 1) & 3, i[5:4], i[3:2], i[1:0], 1'b0, 1'b0);
        for (int i = 0; i < 64; i++)
            go(4, i[5:4], i[3:2], i[1:0], 1'b0, 1'b0);
        for (int i = 0; i < 128; i++)
            go(5, i[5:4], i[3:2], i[1:0], i[6], i[0] ^ i[3]);
        for (int i = 0; i < 16; i++)
            go(6 + (i & 3), i[3:2], i[1:0], i[3:2], 1'b0, i[2]);
        // Unmapped and read-only places drop writes
        wb(1'b1, 8'h3c, 32'hffffffff, q);
        wb(1'b0, 8'h3c, 32'h0, q);
        check("unmapped", q, 32'h0);
        wb(1'b1, spc_pkg::ADDR_SEL_AB, 32'h12345678, q);
        wb(1'b0, spc_pkg::ADDR_SEL_AB, 32'h0, q);
        check("sel readonly", q, {exp_sel[1], exp_sel[0]});
        complete_run();
    end
endmodule // spc_checker_top_tb

// File: bench/spc_exec_model.sv
module spc_exec_model (
    input  wire logic          core_clk,
    input  wire logic          req_ready,
    input  wire logic          grant,
    input  wire logic          general_protection_fault,
    input  wire logic [2:0]    fault_cause,
    output logic               req_valid,
    output spc_pkg::spc_kind_t req_kind,
    output logic [15:0]        req_selector,
    output logic [63:0]        req_descriptor,
    output logic [63:0]        req_offset
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        req_valid = 1'b0;
        req_kind = spc_pkg::K_NEAR;
        req_selector = 16'h0;
        req_descriptor = 64'h0;
        req_offset = 64'h0;
    end
    // Released fields are inverted so stale values never pass as held
    task automatic issue(input spc_pkg::spc_kind_t k, input logic [15:0] s, input logic [63:0] d,
                         input logic [63:0] o, output logic g, output logic f, output logic [2:0] c);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_selector <= s;
        req_descriptor <= d;
        req_offset <= o;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req_selector <= ~s;
        req_descriptor <= ~d;
        req_offset <= ~o;
        do @(posedge core_clk); while (grant !== 1'b1 && general_protection_fault !== 1'b1);
        g = grant;
        f = general_protection_fault;
        c = fault_cause;
    endtask
endmodule // spc_exec_model

// File: rtl/spc_check.sv
module spc_check (
    input  wire spc_pkg::spc_kind_t  kind,
    input  wire spc_pkg::spc_level_t current_priv_level,
    input  wire spc_pkg::spc_level_t requestor_priv_level,
    input  wire spc_pkg::spc_level_t descriptor_priv_level,
    input  wire logic                conforming,
    input  wire logic                long_mode,
    output logic                     ok,
    output spc_pkg::spc_cause_t      cause
);

    always_comb
    begin
        cause = spc_pkg::C_NONE;
        case (kind)
            spc_pkg::K_DATA_A, spc_pkg::K_DATA_B, spc_pkg::K_DATA_C, spc_pkg::K_DATA_D:
            begin
                if (spc_pkg::lvl_max(current_priv_level, requestor_priv_level) > descriptor_priv_level)
                    cause = spc_pkg::C_DATA_PRIV;
            end
            spc_pkg::K_STACK:
            begin
                // Requestor test takes priority over descriptor test
                if (requestor_priv_level != current_priv_level)
                    cause = spc_pkg::C_STACK_RPL;
                else if (descriptor_priv_level != current_priv_level)
                    cause = spc_pkg::C_STACK_DPL;
            end
            spc_pkg::K_FAR:
            begin
                if (conforming)
                begin
                    if (descriptor_priv_level > current_priv_level)
                        cause = spc_pkg::C_CONF_DPL;
                end
                else if (descriptor_priv_level != current_priv_level)
                    cause = spc_pkg::C_NC_DPL;
                else if (requestor_priv_level > current_priv_level)
                    cause = spc_pkg::C_NC_RPL;
            end
            spc_pkg::K_FAST_ENTRY, spc_pkg::K_FAST_EXIT, spc_pkg::K_TASK_SW:
            begin
                if (long_mode)
                    cause = spc_pkg::C_LONG_UNSUP;
            end
            default: cause = spc_pkg::C_NONE;
        endcase
        ok = (cause == spc_pkg::C_NONE);
    end

endmodule // spc_check

// File: rtl/spc_checker_top.sv
// Overview of operation
// - Privilege levels are two bits, 0 most privileged, 3 least.
// - Current level held inside; requestor from selector; descriptor level from entry.
// - Data loads use the larger of current and requestor level.
// - Effective level at most descriptor level: load selector and hidden descriptor.
// - Effective level above descriptor level: fault, data register unchanged.
// - Stack load needs requestor level equal to current level, else fault.
// - Stack load needs descriptor level equal to current level, else fault.
// - Passing far transfer loads code selector and instruction pointer from offset.
// - Near transfers are never checked.
// - Direct far transfers change neither level nor stack.
// - Conforming flag picks the check used for a direct transfer.
// - Nonconforming: descriptor level must equal current level, else fault.
// - Nonconforming: requestor level must not exceed current level, else fault.
// - Nonconforming grant keeps current level, ignores selector requestor level.
// - Conforming: descriptor level at most current level, else fault.
// - Conforming: requestor level plays no part in the decision.
// - Conforming grant writes old current level into loaded code selector.
// - In long mode fast system entry and exit are refused.
// - In long mode call or jump task switches are refused.
module spc_checker_top (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic                    wb_ack_o,
    output logic [31:0]             wb_dat_o,
    input  wire logic               req_valid,
    input  wire spc_pkg::spc_kind_t req_kind,
    input  wire logic [15:0]        req_selector,
    input  wire logic [63:0]        req_descriptor,
    input  wire logic [63:0]        req_offset,
    output logic                    req_ready,
    output logic                    grant,
    output logic                    general_protection_fault,
    output logic [2:0]              fault_cause
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    spc_pkg::spc_state_t state_q, state_d;
    spc_pkg::spc_kind_t  cap_kind_q, cap_kind_d, last_kind_q, last_kind_d;
    logic [15:0]         cap_sel_q, cap_sel_d;
    logic [63:0]         cap_desc_q, cap_desc_d;
    logic [63:0]         cap_off_q, cap_off_d;
    logic [15:0]         seg_sel_q [spc_pkg::NUM_SEGS];
    logic [15:0]         seg_sel_d [spc_pkg::NUM_SEGS];
    logic [63:0]         seg_desc_q [spc_pkg::NUM_SEGS];
    logic [63:0]         seg_desc_d [spc_pkg::NUM_SEGS];
    logic [63:0]         ip_q, ip_d;
    spc_pkg::spc_level_t cpl_q, cpl_d;
    logic                long_q, long_d;
    logic                ready_q, ready_d;
    logic                grant_q, grant_d;
    logic                fault_q, fault_d;
    spc_pkg::spc_cause_t cause_q, cause_d;
    logic                ack_q, ack_d;
    logic [31:0]         dat_q, dat_d;

    spc_pkg::spc_level_t cap_rpl, cap_dpl;
    logic                cap_conf;
    logic                chk_ok;
    spc_pkg::spc_cause_t chk_cause;
    logic                in_check;
    logic [2:0]          desc_idx;
    logic                bus_wr;

    assign cap_rpl  = cap_sel_q[spc_pkg::SEL_RPL_LSB +: 2];
    assign cap_dpl  = cap_desc_q[spc_pkg::DESC_DPL_LSB +: 2];
    assign cap_conf = cap_desc_q[spc_pkg::DESC_CONF_BIT];
    assign in_check = (state_q == spc_pkg::ST_CHECK);
    assign desc_idx = wb_adr_i[5:3];
    assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

    spc_check u_check (
        .kind       (cap_kind_q),
        .current_priv_level        (cpl_q),
        .requestor_priv_level        (cap_rpl),
        .descriptor_priv_level        (cap_dpl),
        .conforming (cap_conf),
        .long_mode  (long_q),
        .ok         (chk_ok),
        .cause      (chk_cause)
    );

    // ----------------------------------------------------------------
    // Request sequencing and architectural state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d     = state_q;
        cap_kind_d  = cap_kind_q;
        cap_sel_d   = cap_sel_q;
        cap_desc_d  = cap_desc_q;
        cap_off_d   = cap_off_q;
        last_kind_d = last_kind_q;
        seg_sel_d   = seg_sel_q;
        seg_desc_d  = seg_desc_q;
        ip_d        = ip_q;
        grant_d     = 1'b0;
        fault_d     = 1'b0;
        cause_d     = cause_q;
        case (state_q)
            spc_pkg::ST_IDLE:
            begin
                if (req_valid)
                begin
                    cap_kind_d = req_kind;
                    cap_sel_d  = req_selector;
                    cap_desc_d = req_descriptor;
                    cap_off_d  = req_offset;
                    state_d    = spc_pkg::ST_CHECK;
                end
            end
            spc_pkg::ST_CHECK:
            begin
                state_d     = spc_pkg::ST_DONE;
                last_kind_d = cap_kind_q;
                cause_d     = chk_cause;
                grant_d     = chk_ok;
                fault_d     = !chk_ok;
                // Nothing architectural moves unless the check passed
                if (chk_ok)
                begin
                    case (cap_kind_q)
                        spc_pkg::K_DATA_A, spc_pkg::K_DATA_B, spc_pkg::K_DATA_C, spc_pkg::K_DATA_D,
                        spc_pkg::K_STACK:
                        begin
                            seg_sel_d[spc_pkg::seg_of_kind(cap_kind_q)]  = cap_sel_q;
                            seg_desc_d[spc_pkg::seg_of_kind(cap_kind_q)] = cap_desc_q;
                        end
                        spc_pkg::K_FAR:
                        begin
                            // Stack slot untouched and level kept: no switch here
                            seg_sel_d[spc_pkg::SEG_CODE]  = {cap_sel_q[15:2], cpl_q};
                            seg_desc_d[spc_pkg::SEG_CODE] = cap_desc_q;
                            ip_d = cap_off_q;
                        end
                        spc_pkg::K_NEAR: ip_d = cap_off_q;
                        default: ip_d = ip_q;
                    endcase
                end
            end
            spc_pkg::ST_DONE: state_d = spc_pkg::ST_IDLE;
            default:          state_d = spc_pkg::ST_IDLE;
        endcase
        ready_d = (state_d == spc_pkg::ST_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q     <= spc_pkg::ST_IDLE;
            cap_kind_q  <= spc_pkg::K_NEAR;
            cap_sel_q   <= 16'h0;
            cap_desc_q  <= 64'h0;
            cap_off_q   <= 64'h0;
            last_kind_q <= spc_pkg::K_NEAR;
            ip_q        <= 64'h0;
            ready_q     <= 1'b1;
            grant_q     <= 1'b0;
            fault_q     <= 1'b0;
            cause_q     <= spc_pkg::C_NONE;
            for (int i = 0; i < spc_pkg::NUM_SEGS; i++)
            begin
                seg_sel_q[i]  <= 16'h0;
                seg_desc_q[i] <= 64'h0;
            end
        end
        else
        begin
            state_q     <= state_d;
            cap_kind_q  <= cap_kind_d;
            cap_sel_q   <= cap_sel_d;
            cap_desc_q  <= cap_desc_d;
            cap_off_q   <= cap_off_d;
            last_kind_q <= last_kind_d;
            seg_sel_q   <= seg_sel_d;
            seg_desc_q  <= seg_desc_d;
            ip_q        <= ip_d;
            ready_q     <= ready_d;
            grant_q     <= grant_d;
            fault_q     <= fault_d;
            cause_q     <= cause_d;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave: one wait state, ack dropped after one cycle
    // ----------------------------------------------------------------
    always_comb
    begin
        cpl_d  = cpl_q;
        long_d = long_q;
        ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
        dat_d  = dat_q;
        // Write lands on the edge where the master sees ack
        if (bus_wr && wb_adr_i == spc_pkg::ADDR_CTRL && wb_sel_i[0])
        begin
            cpl_d  = wb_dat_i[spc_pkg::CTRL_CPL_LSB +: 2];
            long_d = wb_dat_i[spc_pkg::CTRL_LONG_BIT];
        end
        if (ack_d)
        begin
            case (wb_adr_i)
                spc_pkg::ADDR_CTRL:   dat_d = 32'({long_q, cpl_q});
                spc_pkg::ADDR_STATUS: dat_d = 32'({!ready_q, last_kind_q, cause_q});
                spc_pkg::ADDR_SEL_AB: dat_d = {seg_sel_q[1], seg_sel_q[0]};
                spc_pkg::ADDR_SEL_CD: dat_d = {seg_sel_q[3], seg_sel_q[2]};
                spc_pkg::ADDR_SEL_SC: dat_d = {seg_sel_q[spc_pkg::SEG_CODE], seg_sel_q[spc_pkg::SEG_STACK]};
                spc_pkg::ADDR_IP_LO:  dat_d = ip_q[31:0];
                spc_pkg::ADDR_IP_HI:  dat_d = ip_q[63:32];
                default:
                begin
                    // Unmapped words read zero, writes there are dropped
                    dat_d = 32'h0;
                    if (wb_adr_i[7:6] == spc_pkg::DESC_REGION && desc_idx < 3'(spc_pkg::NUM_SEGS))
                        dat_d = wb_adr_i[2] ? seg_desc_q[desc_idx][63:32] : seg_desc_q[desc_idx][31:0];
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpl_q  <= spc_pkg::CPL_RST;
            long_q <= spc_pkg::LONG_RST;
            ack_q  <= 1'b0;
            dat_q  <= 32'h0;
        end
        else
        begin
            cpl_q  <= cpl_d;
            long_q <= long_d;
            ack_q  <= ack_d;
            dat_q  <= dat_d;
        end
    end

    assign wb_ack_o                 = ack_q;
    assign wb_dat_o                 = dat_q;
    assign req_ready                = ready_q;
    assign grant                    = grant_q;
    assign general_protection_fault = fault_q;
    assign fault_cause              = cause_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_take;
        req_valid && ready_q;
    endsequence

    sequence s_one_answer;
        (grant_q ^ fault_q) ##1 !(grant_q || fault_q);
    endsequence

    property p_one_outcome;
        s_take |-> ##2 s_one_answer;
    endproperty
    a_one_outcome: assert property (p_one_outcome) else $error("not exactly one outcome");

    property p_data_grant;
        in_check && spc_pkg::is_data(cap_kind_q) && spc_pkg::lvl_max(cpl_q, cap_rpl) <= cap_dpl
        |=> grant_q && seg_sel_q[spc_pkg::seg_of_kind(cap_kind_q)] == cap_sel_q
            && seg_desc_q[spc_pkg::seg_of_kind(cap_kind_q)] == cap_desc_q;
    endproperty
    a_data_grant: assert property (p_data_grant) else $error("data load not granted");

    property p_data_fault;
        in_check && spc_pkg::is_data(cap_kind_q) && spc_pkg::lvl_max(cpl_q, cap_rpl) > cap_dpl
        |=> fault_q && $stable(seg_sel_q[spc_pkg::seg_of_kind(cap_kind_q)]);
    endproperty
    a_data_fault: assert property (p_data_fault) else $error("data fault missing");

    property p_stack_rpl;
        in_check && cap_kind_q == spc_pkg::K_STACK && cap_rpl != cpl_q
        |=> fault_q && cause_q == spc_pkg::C_STACK_RPL && $stable(seg_sel_q[spc_pkg::SEG_STACK]);
    endproperty
    a_stack_rpl: assert property (p_stack_rpl) else $error("stack requestor fault missing");

    property p_stack_dpl;
        in_check && cap_kind_q == spc_pkg::K_STACK && cap_rpl == cpl_q && cap_dpl != cpl_q
        |=> fault_q && cause_q == spc_pkg::C_STACK_DPL;
    endproperty
    a_stack_dpl: assert property (p_stack_dpl) else $error("stack descriptor fault missing");

    property p_far_load;
        in_check && cap_kind_q == spc_pkg::K_FAR && chk_ok
        |=> ip_q == cap_off_q && seg_sel_q[spc_pkg::SEG_CODE][15:2] == cap_sel_q[15:2];
    endproperty
    a_far_load: assert property (p_far_load) else $error("far transfer not loaded");

    property p_near;
        in_check && cap_kind_q == spc_pkg::K_NEAR
        |=> grant_q && ip_q == cap_off_q && $stable(seg_sel_q[spc_pkg::SEG_CODE]);
    endproperty
    a_near: assert property (p_near) else $error("near transfer checked");

    property p_far_no_stack;
        in_check && cap_kind_q == spc_pkg::K_FAR |=> $stable(seg_sel_q[spc_pkg::SEG_STACK]);
    endproperty
    a_far_no_stack: assert property (p_far_no_stack) else $error("far transfer touched stack");

    property p_nc_dpl;
        in_check && cap_kind_q == spc_pkg::K_FAR && !cap_conf && cap_dpl != cpl_q
        |=> fault_q && cause_q == spc_pkg::C_NC_DPL;
    endproperty
    a_nc_dpl: assert property (p_nc_dpl) else $error("nonconforming level fault missing");

    property p_nc_rpl;
        in_check && cap_kind_q == spc_pkg::K_FAR && !cap_conf && cap_dpl == cpl_q
        |=> (fault_q == (cap_rpl > cpl_q)) && (fault_q || seg_sel_q[spc_pkg::SEG_CODE][1:0] == $past(cpl_q));
    endproperty
    a_nc_rpl: assert property (p_nc_rpl) else $error("nonconforming requestor check wrong");

    property p_conf;
        in_check && cap_kind_q == spc_pkg::K_FAR && cap_conf |=> grant_q == ($past(cap_dpl) <= $past(cpl_q));
    endproperty
    a_conf: assert property (p_conf) else $error("conforming decision wrong");

    property p_conf_rpl;
        in_check && cap_kind_q == spc_pkg::K_FAR && cap_conf && cap_dpl <= cpl_q
        |=> seg_sel_q[spc_pkg::SEG_CODE][1:0] == $past(cpl_q);
    endproperty
    a_conf_rpl: assert property (p_conf_rpl) else $error("conforming selector level wrong");

    property p_long_unsup;
        in_check && long_q && cap_kind_q inside {spc_pkg::K_FAST_ENTRY, spc_pkg::K_FAST_EXIT, spc_pkg::K_TASK_SW}
        |=> fault_q && cause_q == spc_pkg::C_LONG_UNSUP;
    endproperty
    a_long_unsup: assert property (p_long_unsup) else $error("long mode refusal missing");

endmodule // spc_checker_top

// File: rtl/spc_pkg.sv
package spc_pkg;

    // ----------------------------------------------------------------
    // Privilege levels and field positions
    // ----------------------------------------------------------------
    typedef logic [1:0] spc_level_t;
    localparam spc_level_t PL_MOST  = 2'h0;
    localparam spc_level_t PL_LEAST = 2'h3;
    localparam int SEL_RPL_LSB   = 0;
    localparam int DESC_DPL_LSB  = 45;
    localparam int DESC_CONF_BIT = 42;

    // ----------------------------------------------------------------
    // Segment register slots: 0..3 data, then stack, then code
    // ----------------------------------------------------------------
    localparam int         NUM_SEGS  = 6;
    localparam logic [2:0] SEG_STACK = 3'h4;
    localparam logic [2:0] SEG_CODE  = 3'h5;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SEL_AB = 8'h08;
    localparam logic [7:0] ADDR_SEL_CD = 8'h0c;
    localparam logic [7:0] ADDR_SEL_SC = 8'h10;
    localparam logic [7:0] ADDR_IP_LO  = 8'h14;
    localparam logic [7:0] ADDR_IP_HI  = 8'h18;
    localparam logic [1:0] DESC_REGION = 2'h1;
    localparam int CTRL_CPL_LSB  = 0;
    localparam int CTRL_LONG_BIT = 2;
    localparam spc_level_t CPL_RST  = 2'h0;
    localparam logic       LONG_RST = 1'b0;

    typedef enum logic [3:0] {
        K_DATA_A     = 4'h0,
        K_DATA_B     = 4'h1,
        K_DATA_C     = 4'h2,
        K_DATA_D     = 4'h3,
        K_STACK      = 4'h4,
        K_FAR        = 4'h5,
        K_NEAR       = 4'h6,
        K_FAST_ENTRY = 4'h7,
        K_FAST_EXIT  = 4'h8,
        K_TASK_SW    = 4'h9
    } spc_kind_t;

    typedef enum logic [2:0] {
        C_NONE       = 3'h0,
        C_DATA_PRIV  = 3'h1,
        C_STACK_RPL  = 3'h2,
        C_STACK_DPL  = 3'h3,
        C_NC_DPL     = 3'h4,
        C_NC_RPL     = 3'h5,
        C_CONF_DPL   = 3'h6,
        C_LONG_UNSUP = 3'h7
    } spc_cause_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_CHECK = 2'h1,
        ST_DONE  = 2'h3
    } spc_state_t;

    function automatic spc_level_t lvl_max(spc_level_t a, spc_level_t b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic is_data(spc_kind_t k);
        return k inside {K_DATA_A, K_DATA_B, K_DATA_C, K_DATA_D};
    endfunction

    function automatic logic [2:0] seg_of_kind(spc_kind_t k);
        logic [3:0] kb;
        kb = k;
        if (is_data(k))
            return {1'b0, kb[1:0]};
        else if (k == K_STACK)
            return SEG_STACK;
        else
            return SEG_CODE;
    endfunction

endpackage
